// file: include/exp_bridge_pkg.sv
// Package for the expansion bus UART bridge: cycle codes, board address
// layout, control register fields and timing.
// Assumes a single 100 MHz clock shared by both ends.
package exp_bridge_pkg;

   // ==========================================================
   // Bus cycle codes
   localparam logic [7:0] cyc_addr_first  = 8'hc8;
   localparam logic [7:0] cyc_addr_second = 8'hca;
   localparam logic [7:0] cyc_addr_third  = 8'hcc;
   localparam logic [7:0] cyc_write       = 8'hce;
   localparam logic [7:0] cyc_status_read = 8'hc0;
   localparam logic [7:0] cyc_data_read   = 8'hc2;
   localparam logic [7:0] cyc_bus_reset   = 8'hc6;

   // ==========================================================
   // Board address: 00100 00000 xy00R
   localparam logic [4:0] board_addr_first  = 5'h04;
   localparam logic [4:0] board_addr_second = 5'h00;
   localparam int         addr_bits_per_byte = 5;
   localparam int         jumper_x_pos       = 4;
   localparam int         jumper_y_pos       = 3;
   localparam int         reg_sel_pos        = 0;

   // ==========================================================
   // Control register fields
   localparam int         ctl_ce_n_pos   = 5;
   localparam int         ctl_sel0_pos   = 4;
   localparam int         ctl_reset_pos  = 3;
   localparam int         ctl_sel1_pos   = 2;
   localparam int         ctl_driver_pos = 1;
   localparam int         ctl_sel2_pos   = 0;
   localparam logic [7:0] ctl_reset_value = 8'h20;

   // ==========================================================
   // Status bits
   localparam int status_absent_pos = 0;
   localparam int status_irq_pos    = 1;

   // ==========================================================
   // UART select codes and timing
   localparam logic [2:0] sel_mode     = 3'h0;
   localparam logic [2:0] sel_holding  = 3'h3;
   localparam int         clock_mhz          = 100;
   localparam int         uart_reset_min_ns  = 100;
   localparam int         uart_reset_cycles  =
      (uart_reset_min_ns * clock_mhz + 999) / 1000;

   typedef enum logic [1:0] {
      dir_none,
      dir_read,
      dir_write
   } access_dir_type;

endpackage

// file: include/exp_bus_if.sv
// Interface carrying the expansion bus cycles between host and board.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface exp_bus_if;
   logic       cyc_valid;
   logic [7:0] cyc_code;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic       rd_valid;
   logic       attention_n;

   modport board (
      input  cyc_valid,
      input  cyc_code,
      input  wr_data,
      output rd_data,
      output rd_valid,
      output attention_n
   );
   modport host (
      output cyc_valid,
      output cyc_code,
      output wr_data,
      input  rd_data,
      input  rd_valid,
      input  attention_n
   );
endinterface
`default_nettype wire

// file: rtl/exp_uart_board.sv
// Board end of the expansion bus UART bridge: address decode, control
// register, status and data reads, UART register port.
// Assumes a UART core outside, reached through the uart_* ports.
//
// Summary of operation
// - Three address bytes select board register
// - Write cycle stores into addressed register
// - Status bit 0 low when board present
// - Status bit 1 set on UART request
// - Host reads status only with control addressed
// - Data read returns selected UART register
// - Bus-wide reset cycle is ignored
// - Active-low enable gates UART accesses
// - Select bits at positions 4, 2, 0
// - Direction plus select picks internal register
// - Reset bit holds UART in reset
// - Bit 1 powers the line driver
// - Mode code access moves pointer to second mode register
// - UART interrupt drives host attention line
// - Host reselects data by third byte plus one
// - Host pulses reset at least 100 ns
`timescale 1ns/1ps
`default_nettype none
module exp_uart_board #(
   parameter logic [1:0] jumper_xy = 2'h3
) (
   input  wire logic clock,
   input  wire logic rst,
   exp_bus_if.board  bus,
   output logic       uart_ce_n,
   output logic       uart_reset,
   output logic       line_driver_power,
   output logic [2:0] uart_reg_select,
   output logic       uart_wr,
   output logic       uart_rd,
   output logic [7:0] uart_wr_data,
   input  wire logic [7:0] uart_rd_data,
   input  wire logic  uart_irq,
   output logic       mode_reg_second
);

   // ==========================================================
   // Local codes and helpers
   localparam logic [2:0] sel_command      = 3'h2;
   localparam logic [3:0] cmd_mode_ptr_rst = 4'h1;

   function automatic logic cycle_is(input logic       valid,
                                     input logic [7:0] code,
                                     input logic [7:0] want);
      return valid && (code == want);
   endfunction

   function automatic logic [2:0] select_of(input logic [7:0] ctl);
      logic [2:0] sel;
      sel    = 3'h0;
      sel[0] = ctl[exp_bridge_pkg::ctl_sel0_pos];
      sel[1] = ctl[exp_bridge_pkg::ctl_sel1_pos];
      sel[2] = ctl[exp_bridge_pkg::ctl_sel2_pos];
      return sel;
   endfunction

   function automatic logic [7:0] status_of(input logic irq, input logic present);
      logic [7:0] st;
      st                                    = 8'hff;
      st[exp_bridge_pkg::status_absent_pos] = !present;
      st[exp_bridge_pkg::status_irq_pos]    = irq;
      return st;
   endfunction

   // ==========================================================
   // Address capture
   // Only the low five bits of each byte carry address
   logic [4:0] addr_first;
   logic [4:0] addr_second;
   logic [4:0] addr_third;
   logic       board_hit;
   logic       data_selected;
   logic [7:0] board_control;
   logic       first_hit;
   logic       second_hit;
   logic       jumper_hit;
   logic       ctl_addressed;

   always_ff @(posedge clock) begin
      if (rst) begin
         addr_first  <= 5'h00;
         addr_second <= 5'h00;
         addr_third  <= 5'h00;
      end else if (bus.cyc_valid) begin
         case (bus.cyc_code)
            exp_bridge_pkg::cyc_addr_first:  addr_first  <= bus.wr_data[4:0];
            exp_bridge_pkg::cyc_addr_second: addr_second <= bus.wr_data[4:0];
            exp_bridge_pkg::cyc_addr_third:  addr_third  <= bus.wr_data[4:0];
            default: ;
         endcase
      end
   end

   assign first_hit  = (addr_first == exp_bridge_pkg::board_addr_first);
   assign second_hit = (addr_second == exp_bridge_pkg::board_addr_second);
   assign jumper_hit = (addr_third[exp_bridge_pkg::jumper_x_pos] == jumper_xy[1])
                    && (addr_third[exp_bridge_pkg::jumper_y_pos] == jumper_xy[0]);
   // Bits between the jumpers and the register bit must be clear
   assign board_hit  = first_hit && second_hit && jumper_hit && (addr_third[2:1] == 2'h0);
   assign data_selected = addr_third[exp_bridge_pkg::reg_sel_pos];
   assign ctl_addressed = board_hit && !data_selected;

   // ==========================================================
   // Control register
   logic wr_hit;
   assign wr_hit = cycle_is(bus.cyc_valid, bus.cyc_code, exp_bridge_pkg::cyc_write) && board_hit;

   always_ff @(posedge clock) begin
      if (rst) begin
         board_control <= exp_bridge_pkg::ctl_reset_value;
      end else if (wr_hit && !data_selected) begin
         board_control <= bus.wr_data;
      end
   end

   // Bus-wide reset cycle matches no case here
   assign uart_ce_n         = board_control[exp_bridge_pkg::ctl_ce_n_pos];
   assign uart_reset        = board_control[exp_bridge_pkg::ctl_reset_pos];
   assign line_driver_power = board_control[exp_bridge_pkg::ctl_driver_pos];
   assign uart_reg_select   = select_of(board_control);

   // ==========================================================
   // UART access strobes
   logic rd_data_hit;
   logic rd_status_hit;
   logic uart_enabled;
   assign uart_enabled  = !uart_ce_n && !uart_reset;
   assign rd_data_hit   = cycle_is(bus.cyc_valid, bus.cyc_code, exp_bridge_pkg::cyc_data_read)
                       && board_hit && data_selected;
   // Every board answers a status read; bit 0 tells presence
   assign rd_status_hit = cycle_is(bus.cyc_valid, bus.cyc_code, exp_bridge_pkg::cyc_status_read);

   // Writes to the data register while disabled are dropped
   always_ff @(posedge clock) begin
      if (rst) begin
         uart_wr <= 1'b0;
      end else begin
         uart_wr <= wr_hit && data_selected && uart_enabled;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         uart_rd <= 1'b0;
      end else begin
         uart_rd <= rd_data_hit && uart_enabled;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         uart_wr_data <= 8'h00;
      end else if (wr_hit && data_selected) begin
         uart_wr_data <= bus.wr_data;
      end
   end

   // Mode register pointer
   always_ff @(posedge clock) begin
      if (rst || uart_reset) begin
         mode_reg_second <= 1'b0;
      end else if ((uart_wr || uart_rd) && uart_reg_select == exp_bridge_pkg::sel_mode) begin
         mode_reg_second <= 1'b1;
      end else if (uart_wr && uart_reg_select == sel_command && uart_wr_data[7:4] == cmd_mode_ptr_rst) begin
         mode_reg_second <= 1'b0;
      end
   end

   // ==========================================================
   // Read answers
   always_ff @(posedge clock) begin
      if (rst) begin
         bus.rd_valid <= 1'b0;
      end else begin
         bus.rd_valid <= rd_status_hit
                      || cycle_is(bus.cyc_valid, bus.cyc_code, exp_bridge_pkg::cyc_data_read);
      end
   end

   // Unaddressed, disabled or held in reset: the data read floats high
   always_ff @(posedge clock) begin
      if (rst) begin
         bus.rd_data <= 8'hff;
      end else if (rd_status_hit) begin
         bus.rd_data <= status_of(uart_irq, ctl_addressed);
      end else if (rd_data_hit && uart_enabled) begin
         bus.rd_data <= uart_rd_data;
      end else begin
         bus.rd_data <= 8'hff;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bus.attention_n <= 1'b1;
      end else begin
         bus.attention_n <= !uart_irq;
      end
   end

endmodule
`default_nettype wire

// file: rtl/exp_uart_host.sv
// Host end of the expansion bus UART bridge: turns UART register
// requests into address, write and read cycles, and pulses UART reset.
// Assumes the board end joined through exp_bus_if on the same clock.
`timescale 1ns/1ps
`default_nettype none
module exp_uart_host #(
   parameter logic [1:0] jumper_xy = 2'h3
) (
   input  wire logic clock,
   input  wire logic rst,
   exp_bus_if.host   bus,
   input  wire logic       req_valid,
   input  wire logic       req_write,
   input  wire logic       req_status,
   input  wire logic       req_reset,
   input  wire logic [2:0] req_select,
   input  wire logic [7:0] req_data,
   output logic       req_ready,
   output logic       resp_valid,
   output logic [7:0] resp_data,
   output logic       irq_pending
);

   typedef enum logic [3:0] {
      st_idle, st_a0, st_a1, st_a2, st_ctl, st_a2d, st_xfer, st_wait, st_rst_hi, st_rst_lo
   } state_type;

   state_type  state;
   logic       op_write;
   logic       op_status;
   logic [7:0] op_data;
   logic [7:0] op_ctl;
   logic [7:0] hold_count;
   logic [4:0] ctl_byte;

   assign ctl_byte  = {jumper_xy, 3'h0};
   assign req_ready = (state == st_idle);
   assign irq_pending = !bus.attention_n;

   function automatic logic [7:0] ctl_value(input logic [2:0] sel, input logic rst_bit);
      logic [7:0] v;
      v = 8'h00;
      v[exp_bridge_pkg::ctl_sel0_pos]   = sel[0];
      v[exp_bridge_pkg::ctl_sel1_pos]   = sel[1];
      v[exp_bridge_pkg::ctl_sel2_pos]   = sel[2];
      v[exp_bridge_pkg::ctl_driver_pos] = 1'b1;
      v[exp_bridge_pkg::ctl_reset_pos]  = rst_bit;
      return v;
   endfunction

   // ==========================================================
   // Sequencer
   always_ff @(posedge clock) begin
      if (rst) begin
         state      <= st_idle;
         op_write   <= 1'b0;
         op_status  <= 1'b0;
         op_data    <= 8'h00;
         op_ctl     <= 8'h00;
         hold_count <= 8'h00;
      end else begin
         case (state)
            st_idle: if (req_valid) begin
               op_write  <= req_write;
               op_status <= req_status;
               op_data   <= req_data;
               op_ctl    <= ctl_value(req_select, req_reset);
               state     <= st_a0;
            end
            st_a0: state <= st_a1;
            st_a1: state <= st_a2;
            st_a2: state <= op_status ? st_xfer : st_ctl;
            st_ctl: begin
               if (op_ctl[exp_bridge_pkg::ctl_reset_pos]) begin
                  hold_count <= 8'(exp_bridge_pkg::uart_reset_cycles);
                  state      <= st_rst_hi;
               end else begin
                  state <= st_a2d;
               end
            end
            st_rst_hi: if (hold_count <= 8'h01) state <= st_rst_lo;
               else hold_count <= hold_count - 8'h01;
            st_rst_lo: state <= st_idle;
            st_a2d: state <= st_xfer;
            st_xfer: state <= op_write ? st_idle : st_wait;
            st_wait: if (bus.rd_valid) state <= st_idle;
            default: state <= st_idle;
         endcase
      end
   end

   // ==========================================================
   // Bus cycle drive
   always_ff @(posedge clock) begin
      if (rst) begin
         bus.cyc_valid <= 1'b0;
         bus.cyc_code  <= 8'h00;
         bus.wr_data   <= 8'h00;
      end else begin
         bus.cyc_valid <= 1'b0;
         case (state)
            st_a0: begin
               bus.cyc_valid <= 1'b1;
               bus.cyc_code  <= exp_bridge_pkg::cyc_addr_first;
               bus.wr_data   <= {3'h0, exp_bridge_pkg::board_addr_first};
            end
            st_a1: begin
               bus.cyc_valid <= 1'b1;
               bus.cyc_code  <= exp_bridge_pkg::cyc_addr_second;
               bus.wr_data   <= {3'h0, exp_bridge_pkg::board_addr_second};
            end
            st_a2: begin
               bus.cyc_valid <= 1'b1;
               bus.cyc_code  <= exp_bridge_pkg::cyc_addr_third;
               bus.wr_data   <= {3'h0, ctl_byte};
            end
            st_ctl: begin
               bus.cyc_valid <= 1'b1;
               bus.cyc_code  <= exp_bridge_pkg::cyc_write;
               bus.wr_data   <= op_ctl;
            end
            st_rst_lo: begin
               bus.cyc_valid <= 1'b1;
               bus.cyc_code  <= exp_bridge_pkg::cyc_write;
               bus.wr_data   <= op_ctl & ~(8'h01 << exp_bridge_pkg::ctl_reset_pos);
            end
            st_a2d: begin
               bus.cyc_valid <= 1'b1;
               bus.cyc_code  <= exp_bridge_pkg::cyc_addr_third;
               bus.wr_data   <= {3'h0, ctl_byte + 5'h01};
            end
            st_xfer: begin
               bus.cyc_valid <= 1'b1;
               bus.cyc_code  <= op_status ? exp_bridge_pkg::cyc_status_read
                              : op_write ? exp_bridge_pkg::cyc_write
                              : exp_bridge_pkg::cyc_data_read;
               bus.wr_data   <= op_data;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         resp_valid <= 1'b0;
         resp_data  <= 8'h00;
      end else begin
         resp_valid <= (state == st_wait) && bus.rd_valid;
         if ((state == st_wait) && bus.rd_valid) resp_data <= bus.rd_data;
      end
   end

endmodule
`default_nettype wire

// file: verif/exp_bus_checker.sv
// Checker on the expansion bus between host and board ends.
// Assumes one clock; the bench wires the interface signals in by name.
`timescale 1ns/1ps
`default_nettype none
module exp_bus_checker #(
   parameter logic [1:0] jumper_xy = 2'h3
) (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       cyc_valid,
   input wire logic [7:0] cyc_code,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic       rd_valid,
   input wire logic       attention_n
);
   // ====================
   // Addressed register and reset pulse tracking
   logic       data_sel;
   logic       rst_held;
   logic [7:0] prev_code;
   logic [7:0] held_cnt;
   wire logic  is_wr = cyc_valid && cyc_code == exp_bridge_pkg::cyc_write;
   wire logic  is_st = cyc_valid && cyc_code == exp_bridge_pkg::cyc_status_read;
   wire logic  is_rd = is_st || (cyc_valid && cyc_code == exp_bridge_pkg::cyc_data_read);
   wire logic  is_a3 = cyc_valid && cyc_code == exp_bridge_pkg::cyc_addr_third;
   wire logic  ctl_wr = is_wr && !data_sel;
   always_ff @(posedge clock) begin
      if (rst) begin
         data_sel  <= 1'b0;
         prev_code <= 8'h00;
      end else if (cyc_valid) begin
         prev_code <= cyc_code;
         data_sel  <= is_a3 ? wr_data[0] : data_sel;
      end
   end
   always_ff @(posedge clock) begin
      if (rst || ctl_wr) begin
         rst_held <= !rst && wr_data[3];
         held_cnt <= 8'h00;
      end else if (held_cnt != 8'hff) begin
         held_cnt <= held_cnt + 8'h01;
      end
   end
   // ====================
   // Properties
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_first;
      cyc_valid && cyc_code == exp_bridge_pkg::cyc_addr_first;
   endsequence
   sequence s_second;
      cyc_valid && cyc_code == exp_bridge_pkg::cyc_addr_second
         && wr_data[4:0] == exp_bridge_pkg::board_addr_second;
   endsequence
   a_first_byte: assert property (s_first |-> wr_data[4:0] == exp_bridge_pkg::board_addr_first)
      else $error("first address byte wrong");
   a_byte_order: assert property (s_first |-> ##[1:4] s_second)
      else $error("second address byte missing");
   a_read_answer: assert property (is_rd |=> rd_valid)
      else $error("read cycle not answered");
   a_no_stray: assert property (rd_valid |-> $past(is_rd))
      else $error("answer without read cycle");
   a_status_ctl: assert property (is_st |-> !data_sel)
      else $error("status read with data register addressed");
   a_data_reg: assert property (is_rd && !is_st |-> data_sel)
      else $error("data read with control register addressed");
   a_present_bit: assert property (rd_valid && $past(is_st) |-> !rd_data[0])
      else $error("presence bit not low");
   a_irq_bit: assert property (rd_valid && $past(is_st) && $stable(attention_n) |-> rd_data[1] == !attention_n)
      else $error("service bit differs from attention");
   a_reselect: assert property (is_a3 && wr_data[0] |-> prev_code == exp_bridge_pkg::cyc_write
      && wr_data[4:0] == {jumper_xy, 3'h1})
      else $error("data register reselected wrongly");
   a_reset_width: assert property (ctl_wr && rst_held |-> held_cnt >= exp_bridge_pkg::uart_reset_cycles - 1)
      else $error("reset pulse too short");
   a_reset_ends: assert property (ctl_wr && wr_data[3] |=> ##[9:200] (ctl_wr && !wr_data[3]))
      else $error("reset pulse not ended");
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Bench: host and board joined by one bus, plus a second board driven
// directly for cycles the host never makes. Assumes package compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ====================
   // Signals
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_write = 1'b0;
   logic        req_status = 1'b0;
   logic        req_reset = 1'b0;
   logic [2:0]  req_select = 3'h0;
   logic [7:0]  req_data = 8'h00;
   logic [7:0]  uart_rd_data = 8'h00;
   logic        uart_irq = 1'b0;
   logic        req_ready, resp_valid, irq_pending, uart_ce_n, uart_reset, b_ce_n, b_wr;
   logic        line_driver_power, uart_wr, uart_rd, mode_reg_second;
   logic [2:0]  uart_reg_select, b_sel;
   logic [7:0]  resp_data, uart_wr_data;
   logic [31:0] seed = 32'ha4b6;
   logic [10:0] rq[$], wq[$], bq[$];
   int          n_errors = 0, total_checks = 0, cycles = 0, rst_cnt = 0, rd_pulses = 0;
   always #5 clock = ~clock;
   exp_bus_if bus_a ();
   exp_bus_if bus_b ();
   exp_uart_host u_exp_uart_host (.*, .bus(bus_a));
   exp_uart_board u_exp_uart_board (.*, .bus(bus_a));
   exp_uart_board u_exp_uart_board_b (.clock(clock), .rst(rst), .bus(bus_b), .uart_ce_n(b_ce_n),
      .uart_reset(), .line_driver_power(), .uart_reg_select(b_sel), .uart_wr(b_wr), .uart_rd(),
      .uart_wr_data(), .uart_rd_data(uart_rd_data), .uart_irq(uart_irq), .mode_reg_second());
   exp_bus_checker #(.jumper_xy(2'h3)) u_exp_bus_checker (.clock(clock), .rst(rst),
      .cyc_valid(bus_a.cyc_valid), .cyc_code(bus_a.cyc_code), .wr_data(bus_a.wr_data),
      .rd_data(bus_a.rd_data), .rd_valid(bus_a.rd_valid), .attention_n(bus_a.attention_n));
   // ====================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic op(input logic w, s, r, input logic [2:0] sel, input logic [7:0] d);
      @(negedge clock);
      {req_valid, req_write, req_status, req_reset, req_select, req_data} = {1'b1, w, s, r, sel, d};
      @(posedge clock iff req_ready === 1'b1);
      @(negedge clock);
      req_valid = 1'b0;
      @(negedge clock iff (req_ready === 1'b1 && rq.size() == 0));
      repeat (3) @(negedge clock);
   endtask
   task automatic cyc(input logic [7:0] code, input logic [7:0] d);
      @(negedge clock);
      {bus_b.cyc_valid, bus_b.cyc_code, bus_b.wr_data} = {1'b1, code, d};
      @(negedge clock);
      {bus_b.cyc_valid, bus_b.cyc_code, bus_b.wr_data} = {1'b0, ~code, ~d};
   endtask
   task automatic adr(input logic [7:0] third);
      cyc(exp_bridge_pkg::cyc_addr_first, 8'h04);
      cyc(exp_bridge_pkg::cyc_addr_second, 8'h00);
      cyc(exp_bridge_pkg::cyc_addr_third, third);
   endtask
   // ====================
   // Result watcher
   always @(posedge clock) begin
      cycles++;
      rst_cnt = (uart_reset === 1'b1) ? rst_cnt + 1 : rst_cnt;
      rd_pulses = (uart_rd === 1'b1) ? rd_pulses + 1 : rd_pulses;
      if (resp_valid === 1'b1) chk({3'h0, resp_data}, rq.pop_front());
      if (uart_wr === 1'b1) chk({uart_reg_select, uart_wr_data}, wq.pop_front());
      if (bus_b.rd_valid === 1'b1) chk({3'h0, bus_b.rd_data}, bq.pop_front());
      if (b_wr === 1'b1) chk(11'h1, 11'h0);
      if (cycles > 20000) begin
         n_errors++;
         wrap_up();
      end
   end
   // ====================
   // Main sequence
   initial begin
      {bus_b.cyc_valid, bus_b.cyc_code, bus_b.wr_data} = 17'h0;
      repeat (8) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      for (int s = 0; s < 8; s++) begin
         seed = xs(seed);
         wq.push_back({3'(s), seed[7:0]});
         op(1'b1, 1'b0, 1'b0, 3'(s), seed[7:0]);
         chk({6'h0, uart_ce_n, line_driver_power, uart_reg_select}, {8'h1, 3'(s)});
      end
      $display("write test done");
      for (int s = 0; s < 8; s++) begin
         seed = xs(seed);
         uart_rd_data = seed[7:0];
         rq.push_back({3'h0, seed[7:0]});
         op(1'b0, 1'b0, 1'b0, 3'(s), 8'h00);
      end
      chk({10'h0, mode_reg_second}, 11'h1);
      chk(11'(rd_pulses), 11'h8);
      $display("read test done");
      for (int b = 0; b < 2; b++) begin
         uart_irq = b[0];
         repeat (4) @(negedge clock);
         chk({10'h0, irq_pending}, {10'h0, b[0]});
         rq.push_back({9'h03f, b[0], 1'b0});
         op(1'b0, 1'b1, 1'b0, 3'h0, 8'h00);
      end
      $display("status test done");
      rst_cnt = 0;
      op(1'b0, 1'b0, 1'b1, 3'h0, 8'h00);
      chk({10'h0, uart_reset}, 11'h0);
      chk(11'(rst_cnt >= exp_bridge_pkg::uart_reset_cycles), 11'h1);
      chk({10'h0, mode_reg_second}, 11'h0);
      wq.push_back({3'h0, 8'h5a});
      op(1'b1, 1'b0, 1'b0, 3'h0, 8'h5a);
      chk({10'h0, mode_reg_second}, 11'h1);
      wq.push_back({3'h2, 8'h10});
      op(1'b1, 1'b0, 1'b0, 3'h2, 8'h10);
      chk({10'h0, mode_reg_second}, 11'h0);
      rq.push_back({3'h0, uart_rd_data});
      op(1'b0, 1'b0, 1'b0, 3'h0, 8'h00);
      chk({10'h0, mode_reg_second}, 11'h1);
      $display("reset and mode test done");
      bq.push_back(11'h0ff);
      cyc(exp_bridge_pkg::cyc_status_read, 8'h00);
      adr(8'h18);
      cyc(exp_bridge_pkg::cyc_write, 8'h16);
      cyc(exp_bridge_pkg::cyc_bus_reset, 8'h00);
      repeat (2) @(negedge clock);
      chk({7'h0, b_ce_n, b_sel}, 11'h3);
      cyc(exp_bridge_pkg::cyc_addr_third, 8'h19);
      bq.push_back(11'h0ff);
      cyc(exp_bridge_pkg::cyc_status_read, 8'h00);
      seed = xs(seed);
      uart_rd_data = seed[7:0];
      bq.push_back({3'h0, seed[7:0]});
      cyc(exp_bridge_pkg::cyc_data_read, 8'h00);
      adr(8'h18);
      cyc(exp_bridge_pkg::cyc_write, 8'h36);
      cyc(exp_bridge_pkg::cyc_addr_third, 8'h19);
      cyc(exp_bridge_pkg::cyc_write, 8'h55);
      bq.push_back(11'h0ff);
      cyc(exp_bridge_pkg::cyc_data_read, 8'h00);
      repeat (4) @(negedge clock);
      chk(11'(wq.size() + rq.size() + bq.size()), 11'h0);
      $display("direct board test done");
      wrap_up();
   end
endmodule
`default_nettype wire
